// ==== shared/brw_pkg.sv ====
`default_nettype none
package brw_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LEN_W = 6;
  // ----------------------------------------
  // Access phase length limits, in bus clocks
  // ----------------------------------------
  localparam logic [LEN_W-1:0] ACCESS_LEN_MIN = 6'h01;
  localparam logic [LEN_W-1:0] ACCESS_LEN_MAX = 6'h20;
  // Extra synchroniser wait in asynchronous ready mode
  localparam logic [LEN_W-1:0] ASYNC_EXTRA_WAIT = 6'h01;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic STROBE_IDLE_N = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [LEN_W-1:0] LEN_RST = 6'h01;
  // ----------------------------------------
  // Bus cycle states
  // ----------------------------------------
  typedef enum logic [2:0] {
    BRW_IDLE,
    BRW_ACCESS,
    BRW_SYNC_WAIT,
    BRW_READY,
    BRW_END
  } brw_state_t;
endpackage
`default_nettype wire

// ==== hdl/brw_ready_ctrl.sv ====
// Overview of operation
// - External circuit stretches a bus cycle through ready when ready is enabled; otherwise the cycle ends after the access phase.
// - Configuration input selects ready polarity, active high or active low.
// - Synchronous ready is sampled directly on bus clock, shortest cycle.
// - Asynchronous ready passes an extra synchroniser, costing at least one wait.
// - Ready sampled inactive inserts one more wait state, then samples again.
// - Ready sampled active terminates the running bus cycle.
// - Asynchronous sample point lies one bus clock later than synchronous.
// - Ready is ignored until the programmed access phase has elapsed.
// - Read data latched on the edge that raises the read strobe.
`default_nettype none
module brw_ready_ctrl
  import brw_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  // Core request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_rdata,
  // Configuration levels, sampled with each request
  input wire logic cfg_ready_enable,
  input wire logic cfg_ready_active_high,
  input wire logic cfg_ready_async,
  input wire logic [LEN_W-1:0] cfg_access_len,
  // Bus side, on the bus clock
  input wire logic bus_clock,
  input wire logic ready_pin,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [ADDR_W-1:0] addr_out,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic ready_wait_state
);

  // ----------------------------------------
  // Core domain: request capture and handshake
  // ----------------------------------------
  logic busy_q;
  logic req_tog_q;
  logic hold_write_q;
  logic [ADDR_W-1:0] hold_addr_q;
  logic [DATA_W-1:0] hold_wdata_q;
  logic hold_rdy_en_q;
  logic hold_rdy_hi_q;
  logic hold_rdy_async_q;
  logic [LEN_W-1:0] hold_len_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic done_evt;
  logic take;
  logic done_tog_q;
  logic [DATA_W-1:0] bus_rdata_q;

  assign req_ready = !busy_q;
  assign take = req_valid && !busy_q;
  assign done_evt = done_s2_q ^ done_s3_q;

  // Busy flag and request toggle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      req_tog_q <= 1'b0;
    end else if (take) begin
      busy_q <= 1'b1;
      req_tog_q <= !req_tog_q;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end
  end

  // Held request words; stable while busy
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_write_q <= 1'b0;
      hold_addr_q <= ADDR_RST;
      hold_wdata_q <= DATA_RST;
      hold_rdy_en_q <= 1'b0;
      hold_rdy_hi_q <= 1'b0;
      hold_rdy_async_q <= 1'b0;
      hold_len_q <= LEN_RST;
    end else if (take) begin
      hold_write_q <= req_write;
      hold_addr_q <= req_addr;
      hold_wdata_q <= req_wdata;
      hold_rdy_en_q <= cfg_ready_enable;
      hold_rdy_hi_q <= cfg_ready_active_high;
      hold_rdy_async_q <= cfg_ready_async;
      // Clamp length into the legal access phase range
      if (cfg_access_len < ACCESS_LEN_MIN) begin
        hold_len_q <= ACCESS_LEN_MIN;
      end else if (cfg_access_len > ACCESS_LEN_MAX) begin
        hold_len_q <= ACCESS_LEN_MAX;
      end else begin
        hold_len_q <= cfg_access_len;
      end
    end
  end

  // Completion toggle synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_tog_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  // Response pulse and read data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      resp_valid <= 1'b0;
      resp_rdata <= DATA_RST;
    end else begin
      resp_valid <= done_evt;
      if (done_evt && !hold_write_q) begin
        resp_rdata <= bus_rdata_q;
      end
    end
  end

  // ----------------------------------------
  // Bus domain: synchronisers
  // ----------------------------------------
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic req_evt;
  logic [SYNC_STAGES-1:0] rdy_sync_q;
  logic rdy_sync_lvl;
  logic rdy_raw_act;
  logic rdy_async_act;

  assign req_evt = req_s2_q ^ req_s3_q;

  // Request toggle synchroniser
  always_ff @(posedge bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Asynchronous ready chain
  always_ff @(posedge bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      rdy_sync_q <= '0;
    end else begin
      rdy_sync_q <= {rdy_sync_q[SYNC_STAGES-2:0], ready_pin};
    end
  end

  assign rdy_sync_lvl = rdy_sync_q[SYNC_STAGES-1];
  // Polarity applied after the chain, so only the last stage is read
  assign rdy_raw_act = hold_rdy_hi_q ? ready_pin : !ready_pin;
  assign rdy_async_act = hold_rdy_hi_q ? rdy_sync_lvl : !rdy_sync_lvl;

  // ----------------------------------------
  // Bus domain: cycle sequencer
  // ----------------------------------------
  brw_state_t state_q;
  logic [LEN_W-1:0] cnt_q;
  logic rdy_act;

  assign rdy_act = hold_rdy_async_q ? rdy_async_act : rdy_raw_act;

  // State and access counter
  always_ff @(posedge bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= BRW_IDLE;
      cnt_q <= LEN_RST;
    end else begin
      case (state_q)
        BRW_IDLE: begin
          if (req_evt) begin
            state_q <= BRW_ACCESS;
            cnt_q <= hold_len_q;
          end
        end
        BRW_ACCESS: begin
          if (cnt_q > ACCESS_LEN_MIN) begin
            cnt_q <= cnt_q - ACCESS_LEN_MIN;
          end else if (!hold_rdy_en_q) begin
            state_q <= BRW_END;
          end else if (hold_rdy_async_q) begin
            state_q <= BRW_SYNC_WAIT;
            cnt_q <= ASYNC_EXTRA_WAIT;
          end else begin
            state_q <= BRW_READY;
          end
        end
        BRW_SYNC_WAIT: begin
          state_q <= BRW_READY;
        end
        BRW_READY: begin
          if (rdy_act) begin
            state_q <= BRW_END;
          end
        end
        BRW_END: begin
          state_q <= BRW_IDLE;
        end
        default: begin
          state_q <= BRW_IDLE;
        end
      endcase
    end
  end

  // Wait state indicator, one bus clock per inactive sample
  always_ff @(posedge bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      ready_wait_state <= 1'b0;
    end else begin
      ready_wait_state <= (state_q == BRW_READY) && !rdy_act;
    end
  end

  // Strobes, address and write data
  always_ff @(posedge bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      read_strobe_n <= STROBE_IDLE_N;
      write_strobe_n <= STROBE_IDLE_N;
      addr_out <= ADDR_RST;
      data_out <= DATA_RST;
      data_oe <= 1'b0;
    end else if (state_q == BRW_IDLE && req_evt) begin
      read_strobe_n <= hold_write_q;
      write_strobe_n <= !hold_write_q;
      addr_out <= hold_addr_q;
      data_out <= hold_wdata_q;
      data_oe <= hold_write_q;
    end else if ((state_q == BRW_READY && rdy_act) ||
                 (state_q == BRW_ACCESS && cnt_q <= ACCESS_LEN_MIN && !hold_rdy_en_q)) begin
      read_strobe_n <= STROBE_IDLE_N;
      write_strobe_n <= STROBE_IDLE_N;
    end else if (state_q == BRW_END) begin
      data_oe <= 1'b0;
    end
  end

  // Read data latch on the strobe rising edge, completion toggle at end
  always_ff @(posedge bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata_q <= DATA_RST;
      done_tog_q <= 1'b0;
    end else begin
      if (!read_strobe_n && ((state_q == BRW_READY && rdy_act) ||
          (state_q == BRW_ACCESS && cnt_q <= ACCESS_LEN_MIN && !hold_rdy_en_q))) begin
        bus_rdata_q <= data_in;
      end
      if (state_q == BRW_END) begin
        done_tog_q <= !done_tog_q;
      end
    end
  end

endmodule
`default_nettype wire

// ==== bench/brw_chk.sv ====
`default_nettype none
module brw_chk
  import brw_pkg::*;
(
  input wire logic bus_clock,
  input wire logic reset_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_oe,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic ready_wait_state,
  input wire logic cfg_ready_enable,
  input wire logic cfg_ready_async
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Bus side checks
  // ----------------------------------------
  default clocking cb @(posedge bus_clock); endclocking
  default disable iff (!reset_n);
  // High while no strobe is active
  wire logic idle = read_strobe_n & write_strobe_n;
  AST_EXCL: assert property (read_strobe_n | write_strobe_n)
    else $error("strobes overlap");
  AST_WAIT_IN: assert property (ready_wait_state |-> !idle)
    else $error("wait outside cycle");
  AST_ACC_NOWAIT: assert property ($fell(idle) |-> !ready_wait_state)
    else $error("wait in access phase");
  AST_ASYNC_NOWAIT: assert property ($fell(idle) && cfg_ready_async |-> !ready_wait_state[*2])
    else $error("async wait too early");
  AST_MIN_SYNC: assert property ($fell(idle) && cfg_ready_enable |-> !idle[*2])
    else $error("cycle too short");
  AST_MIN_ASYNC: assert property ($fell(idle) && cfg_ready_enable && cfg_ready_async |-> !idle[*3])
    else $error("async cycle too short");
  AST_ADDR: assert property (!idle && $past(!idle) |-> $stable(addr_out))
    else $error("address moved");
  AST_WDATA: assert property (!write_strobe_n && $past(!write_strobe_n) |-> $stable(data_out))
    else $error("write data moved");
  AST_OE: assert property ($rose(data_oe) |-> !write_strobe_n)
    else $error("drive outside write");
  AST_RD_OE: assert property (!read_strobe_n |-> !data_oe)
    else $error("drive during read");
  // Main scenarios
  cover property ($rose(ready_wait_state));
  cover property ($fell(idle) && cfg_ready_async);
  cover property ($fell(read_strobe_n));
endmodule
bind brw_ready_ctrl brw_chk i_chk (.bus_clock, .reset_n, .read_strobe_n, .write_strobe_n,
  .data_oe, .addr_out, .data_out, .ready_wait_state, .cfg_ready_enable, .cfg_ready_async);
`default_nettype wire

// ==== bench/brw_far_model.sv ====
`default_nettype none
module brw_far_model
  import brw_pkg::*;
(
  input wire logic bus_clock,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic act_high,
  input wire logic [5:0] hold,
  output logic ready_pin,
  output logic [DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // External circuit
  // ----------------------------------------
  logic [5:0] n = 6'h00;
  wire logic idle = read_strobe_n & write_strobe_n;
  // Bus clocks into the running cycle
  always @(posedge bus_clock) n <= idle ? 6'h00 : n + {5'h00, n != 6'h3f};
  // Ready after hold clocks, never for 3f, dropped at the strobe rise
  assign #3 ready_pin = (!idle && n >= hold && hold != 6'h3f) ? act_high : !act_high;
  // Read data while selected, inverse once released
  assign #3 data_in = addr_out[15:0] ^ (read_strobe_n ? 16'ha5a5 : 16'h5a5a);
endmodule
`default_nettype wire

// ==== bench/test_brw_ready_ctrl.sv ====
`default_nettype none
module test_brw_ready_ctrl
  import brw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, reset_n = 0, bus_clock = 0, req_valid = 0, req_write = 0;
  logic cfg_ready_enable = 0, cfg_ready_active_high = 1, cfg_ready_async = 0;
  logic [LEN_W-1:0] cfg_access_len = 6'h01;
  logic [5:0] hold = 6'h00;
  logic [ADDR_W-1:0] req_addr = 24'h000000;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  wire logic req_ready, resp_valid, ready_pin, data_oe, read_strobe_n, write_strobe_n;
  wire logic ready_wait_state;
  wire logic [DATA_W-1:0] resp_rdata, data_in, data_out;
  wire logic [ADDR_W-1:0] addr_out;
  int num_errors = 0, num_checks = 0, cnt = 0, wc = 0, len_q = 0, w_q = 0;
  logic [31:0] a_q, d_q, oe_q, s_q;
  // ----------------------------------------
  // Clocks, design and far side
  // ----------------------------------------
  initial forever #12.5 clock = !clock;
  initial begin
    #7;
    forever #80 bus_clock = !bus_clock;
  end
  brw_ready_ctrl i_dut (.clock, .reset_n, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .resp_valid, .resp_rdata, .cfg_ready_enable, .cfg_ready_active_high,
    .cfg_ready_async, .cfg_access_len, .bus_clock, .ready_pin, .data_in, .data_out,
    .data_oe, .addr_out, .read_strobe_n, .write_strobe_n, .ready_wait_state);
  brw_far_model i_far (.bus_clock, .read_strobe_n, .write_strobe_n, .addr_out,
    .act_high(cfg_ready_active_high), .hold, .ready_pin, .data_in);
  // Strobe-low length, waits and first-clock bus values
  always @(negedge bus_clock) begin
    if (!(read_strobe_n & write_strobe_n)) begin
      if (cnt == 0) begin
        s_q <= {30'h0, read_strobe_n, write_strobe_n};
        a_q <= addr_out;
        d_q <= data_out;
        oe_q <= data_oe;
      end
      cnt <= cnt + 1;
      wc <= wc + ready_wait_state;
    end else if (cnt != 0) begin
      len_q <= cnt;
      w_q <= wc;
      cnt <= 0;
      wc <= 0;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One bus cycle; m = write, enable, async, active high
  task run(input logic [3:0] m, input logic [5:0] ln, h, output int l, w);
    int i;
    @(negedge clock);
    {req_write, cfg_ready_enable, cfg_ready_async, cfg_ready_active_high} = m;
    cfg_access_len = ln;
    hold = h;
    req_addr = req_addr + 24'h010203;
    req_wdata = ~req_addr[15:0];
    req_valid = 1'b1;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clock);
    if (i == 50) begin
      num_errors++;
      conclude;
    end
    @(negedge clock);
    req_valid = 1'b0;
    for (i = 0; i < 4000 && resp_valid !== 1'b1; i++) @(negedge clock);
    if (i == 4000) begin
      num_errors++;
      conclude;
    end
    l = len_q;
    w = w_q;
    chk(a_q, req_addr);
    chk(s_q, m[3] ? 32'h2 : 32'h1);
    if (m[3]) begin
      chk(d_q, req_wdata);
      chk(oe_q, 32'h1);
    end else begin
      chk(resp_rdata, req_addr[15:0] ^ 16'h5a5a);
      chk(oe_q, 32'h0);
    end
  endtask
  task t_wait;
    int l0, w0, l1, w1, l2, w2;
    run(4'hd, 6'h02, 6'h00, l0, w0);
    run(4'h5, 6'h02, 6'h05, l1, w1);
    run(4'hd, 6'h02, 6'h07, l2, w2);
    chk(w0, 32'h0);
    chk(l2 - l1, 32'h2);
    chk(w2 - w1, 32'h2);
    $display("test wait done");
  endtask
  task t_acc;
    int la, lb, lc, ld, x;
    run(4'h5, 6'h01, 6'h00, la, x);
    run(4'hd, 6'h04, 6'h00, lb, x);
    run(4'h4, 6'h04, 6'h00, lc, x);
    run(4'hf, 6'h04, 6'h00, ld, x);
    chk(lb - la, 32'h3);
    chk(lc, lb);
    chk(ld - lb, ASYNC_EXTRA_WAIT);
    $display("test access done");
  endtask
  task t_off;
    int la, lb, x;
    run(4'h9, 6'h03, 6'h3f, la, x);
    run(4'h0, 6'h03, 6'h00, lb, x);
    chk(la, lb);
    chk(la, 32'h3);
    $display("test off done");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    t_wait;
    t_acc;
    t_off;
    conclude;
  end
endmodule
`default_nettype wire
